// [lis_irq_summary_regs.sv]
`timescale 1ns/1ps
// Operation
// - summary at 300h maps channels 16 to 9
// - summary bit high while channel interrupt pending
// - 380h bit 7 is channel 0, rest zero
// - second overflow sets timer status bit 0
// - writing one clears overflow bit unless a tick coincides, else held
// - writing one to reset bit resets channel
// - channel reset bit clears itself
// - summary at 2C0h maps channels 8 to 1
module lis_irq_summary_regs #(
    parameter int NUM_CH = 17
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [10:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [NUM_CH-1:0] chan_irq_in,
    input wire logic second_tick_in,
    output logic [NUM_CH-1:0] chan_soft_reset_out,
    output logic [NUM_CH-1:0] line_standard_select_out,
    output logic irq_out
);
    generate
        if (NUM_CH != lis_pkg::NUM_CH) begin : g_bad
            $error("address decode serves exactly 17 channels");
        end
    endgenerate

    lis_cfg_if #(.NUM_CH(NUM_CH)) cfg_bus ();

    lis_chan_cfg_bank #(
        .NUM_CH(NUM_CH)
    ) u_bank (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .cfg(cfg_bus.ctl)
    );

    // pending levels come from channel logic on this clock: no synchroniser
    logic [NUM_CH-1:0] pend_r;
    logic [NUM_CH-1:0] pend_nxt;
    logic tm_r;
    logic tm_nxt;
    logic mask_r;
    logic mask_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [NUM_CH-1:0] sel;
    logic hit_lower;
    logic hit_upper;
    logic hit_zero;
    logic hit_tm;
    logic hit_mask;
    logic tm_clr;

    // address decode
    always_comb begin
        sel = '0;
        if (addr_in == lis_pkg::OFS_CFG_CH0) begin
            sel[0] = 1'b1;
        end else if (!addr_in[10] && addr_in[5:0] == lis_pkg::OFS_CFG_LOW) begin
            sel[addr_in[9:6] + 5'd1] = 1'b1;
        end
    end

    assign hit_lower = (addr_in == lis_pkg::OFS_SUM_LOWER);
    assign hit_upper = (addr_in == lis_pkg::OFS_SUM_UPPER);
    assign hit_zero = (addr_in == lis_pkg::OFS_SUM_ZERO);
    assign hit_tm = (addr_in == lis_pkg::OFS_TM_STATUS);
    assign hit_mask = (addr_in == lis_pkg::OFS_IRQ_MASK);
    assign tm_clr = wr_in && hit_tm && wdata_in[lis_pkg::TM_OVF_BIT];

    assign cfg_bus.wr = wr_in;
    assign cfg_bus.sel = sel;
    assign cfg_bus.wdata = wdata_in;

    // state: pending capture, overflow flag, mask
    always_comb begin
        pend_nxt = chan_irq_in;
        // set beats clear so a tick in the clearing cycle is kept
        tm_nxt = (tm_r && !tm_clr) || second_tick_in;
        mask_nxt = mask_r;
        if (wr_in && hit_mask) begin
            mask_nxt = wdata_in[lis_pkg::TM_OVF_BIT];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pend_r <= lis_pkg::RST_CH;
            tm_r <= lis_pkg::RST_BIT;
            mask_r <= lis_pkg::RST_BIT;
        end else begin
            pend_r <= pend_nxt;
            tm_r <= tm_nxt;
            mask_r <= mask_nxt;
        end
    end

    // read path: data in the cycle after the strobe, zero elsewhere
    always_comb begin
        rdata_nxt = lis_pkg::RST_BYTE;
        if (rd_in) begin
            if (hit_lower) begin
                rdata_nxt = pend_r[8:1];
            end else if (hit_upper) begin
                rdata_nxt = pend_r[16:9];
            end else if (hit_zero) begin
                rdata_nxt[lis_pkg::SUM_ZERO_BIT] = pend_r[0];
            end else if (hit_tm) begin
                rdata_nxt[lis_pkg::TM_OVF_BIT] = tm_r;
            end else if (hit_mask) begin
                rdata_nxt[lis_pkg::TM_OVF_BIT] = mask_r;
            end else begin
                for (int k = 0; k < NUM_CH; k++) begin
                    if (sel[k]) begin
                        rdata_nxt[lis_pkg::CFG_RST_BIT] = cfg_bus.rst_bit[k];
                        rdata_nxt[lis_pkg::CFG_STD_BIT] = cfg_bus.e1[k];
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_r <= lis_pkg::RST_BYTE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_out = rdata_r;
    // the reset pulse is the self-clearing bit itself, one cycle wide
    assign chan_soft_reset_out = cfg_bus.rst_bit;
    assign line_standard_select_out = cfg_bus.e1;
    assign irq_out = tm_r && mask_r;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_rd(logic [10:0] a);
        rd_in && addr_in == a;
    endsequence

    sequence s_wr_ch0(logic b);
        wr_in && addr_in == lis_pkg::OFS_CFG_CH0 && wdata_in[lis_pkg::CFG_RST_BIT] == b;
    endsequence

    property p_upper_map;
        s_rd(lis_pkg::OFS_SUM_UPPER) |=> rdata_out == $past(chan_irq_in[16:9], 2);
    endproperty
    a_upper_map: assert property (p_upper_map) else $error("upper summary wrong");

    property p_sum_clear;
        !chan_irq_in[9] ##1 s_rd(lis_pkg::OFS_SUM_UPPER) |=> !rdata_out[0];
    endproperty
    a_sum_clear: assert property (p_sum_clear) else $error("summary stuck high");

    property p_zero_map;
        s_rd(lis_pkg::OFS_SUM_ZERO) |=>
            rdata_out[6:0] == 7'h00 && rdata_out[7] == $past(pend_r[0]);
    endproperty
    a_zero_map: assert property (p_zero_map) else $error("channel zero summary wrong");

    property p_tm_set;
        second_tick_in ##1 s_rd(lis_pkg::OFS_TM_STATUS) |=> rdata_out == 8'h01;
    endproperty
    a_tm_set: assert property (p_tm_set) else $error("overflow flag not set");

    property p_tm_hold;
        tm_r && !tm_clr |=> tm_r;
    endproperty
    a_tm_hold: assert property (p_tm_hold) else $error("overflow flag lost");

    property p_tm_clr;
        tm_clr && !second_tick_in |=> !tm_r && !irq_out;
    endproperty
    a_tm_clr: assert property (p_tm_clr) else $error("overflow flag not cleared");

    property p_chan_soft_reset;
        s_wr_ch0(1'b1) |=> chan_soft_reset_out[0] ##1 !chan_soft_reset_out[0];
    endproperty
    a_chan_soft_reset: assert property (p_chan_soft_reset) else $error("channel reset pulse wrong");

    property p_chan_soft_reset_read;
        // a read two cycles after the write no longer sees the pulse
        s_wr_ch0(1'b1) ##1 !wr_in ##1 s_rd(lis_pkg::OFS_CFG_CH0) |=> !rdata_out[1];
    endproperty
    a_chan_soft_reset_read: assert property (p_chan_soft_reset_read) else $error("reset bit not self cleared");

    property p_std;
        wr_in && addr_in == lis_pkg::OFS_CFG_CH0 |=>
            line_standard_select_out[0] == $past(wdata_in[0]);
    endproperty
    a_std: assert property (p_std) else $error("line standard not taken");

    property p_lower_map;
        s_rd(lis_pkg::OFS_SUM_LOWER) |=> rdata_out == $past(pend_r[8:1]);
    endproperty
    a_lower_map: assert property (p_lower_map) else $error("lower summary wrong");
endmodule

// [lis_pkg.sv]
package lis_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 17;

    // summary and timer registers
    localparam logic [10:0] OFS_SUM_LOWER = 11'h2C0;
    localparam logic [10:0] OFS_SUM_UPPER = 11'h300;
    localparam logic [10:0] OFS_SUM_ZERO = 11'h380;
    localparam logic [10:0] OFS_TM_STATUS = 11'h3C0;
    localparam logic [10:0] OFS_IRQ_MASK = 11'h7C0;

    // channel config: channel n (1..16) at (n-1)*64 + 1, channel 0 alone
    localparam logic [10:0] OFS_CFG_CH0 = 11'h7C1;
    localparam logic [5:0] OFS_CFG_LOW = 6'h01;

    // field positions
    localparam int CFG_STD_BIT = 0;
    localparam int CFG_RST_BIT = 1;
    localparam int TM_OVF_BIT = 0;
    localparam int SUM_ZERO_BIT = 7;

    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [16:0] RST_CH = 17'h0_0000;
    localparam logic RST_BIT = 1'b0;
endpackage

// [lis_cfg_if.sv]
`timescale 1ns/1ps
interface lis_cfg_if #(
    parameter int NUM_CH = 17
);
    logic wr;
    logic [NUM_CH-1:0] sel;
    logic [7:0] wdata;
    logic [NUM_CH-1:0] rst_bit;
    logic [NUM_CH-1:0] e1;

    modport ctl (
        output wr,
        output sel,
        output wdata,
        input rst_bit,
        input e1
    );
    modport bank (
        input wr,
        input sel,
        input wdata,
        output rst_bit,
        output e1
    );
endinterface

// [lis_chan_cfg_bank.sv]
`timescale 1ns/1ps
module lis_chan_cfg_bank #(
    parameter int NUM_CH = 17
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    lis_cfg_if.bank cfg
);
    generate
        if (NUM_CH < 1) begin : g_bad
            $error("channel count must be at least one");
        end
        for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
            logic rst_r;
            logic rst_nxt;
            logic std_r;
            logic std_nxt;

            always_comb begin
                // reset bit lives one cycle only, so a later read sees 0
                rst_nxt = 1'b0;
                std_nxt = std_r;
                if (cfg.wr && cfg.sel[k]) begin
                    rst_nxt = cfg.wdata[lis_pkg::CFG_RST_BIT];
                    std_nxt = cfg.wdata[lis_pkg::CFG_STD_BIT];
                end
            end

            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    rst_r <= lis_pkg::RST_BIT;
                    std_r <= lis_pkg::RST_BIT;
                end else begin
                    rst_r <= rst_nxt;
                    std_r <= std_nxt;
                end
            end

            assign cfg.rst_bit[k] = rst_r;
            assign cfg.e1[k] = std_r;
        end
    endgenerate
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [10:0] addr_in = 11'h000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [16:0] chan_irq_in = 17'h0_0000;
    logic second_tick_in = 1'b0;
    logic [7:0] rdata_out;
    logic [16:0] chan_soft_reset_out;
    logic [16:0] line_standard_select_out;
    logic irq_out;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h9098_25ae;
    logic [7:0] rv;
    logic [16:0] irq_v;
    logic [16:0] exp_mode;
    logic mode;
    // summaries first, then timer, mask, last config and an unmapped hole
    logic [10:0] rmap [7] = '{lis_pkg::OFS_SUM_LOWER, lis_pkg::OFS_SUM_UPPER,
        lis_pkg::OFS_SUM_ZERO, lis_pkg::OFS_TM_STATUS, lis_pkg::OFS_IRQ_MASK,
        11'h3c1, 11'h7ff};

    lis_irq_summary_regs #(.NUM_CH(17)) uut (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .chan_irq_in(chan_irq_in),
        .second_tick_in(second_tick_in),
        .chan_soft_reset_out(chan_soft_reset_out),
        .line_standard_select_out(line_standard_select_out),
        .irq_out(irq_out)
    );

    initial begin
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] exp_sum(input logic [10:0] a, input logic [16:0] v);
        if (a == lis_pkg::OFS_SUM_LOWER) return v[8:1];
        if (a == lis_pkg::OFS_SUM_UPPER) return v[16:9];
        return {v[0], 7'h00};
    endfunction

    function automatic logic [10:0] cfg_addr(input int k);
        if (k == 0) return lis_pkg::OFS_CFG_CH0;
        return 11'((k - 1) * 64 + 1);
    endfunction

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s seen %h want %h", $time, msg, seen, exp);
        end
    endtask

    // one idle cycle between transfers keeps each strobe a clean pulse
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic tick();
        @(posedge ref_clk_in);
        second_tick_in <= 1'b1;
        @(posedge ref_clk_in);
        second_tick_in <= 1'b0;
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(rmap[i], rv);
            chk(rv, 8'h00, "reset value");
        end
        chk(irq_out, 1'h0, "irq idle");
        $display("test done: reset values");
        for (int n = 0; n < 20; n++) begin
            seed = xorshift(seed);
            irq_v = (n == 0) ? 17'h1_ffff : (n == 1) ? 17'h0_0001 : seed[16:0];
            @(posedge ref_clk_in);
            chan_irq_in <= irq_v;
            for (int i = 0; i < 3; i++) begin
                rd(rmap[i], rv);
                chk(rv, exp_sum(rmap[i], irq_v), "summary");
            end
        end
        @(posedge ref_clk_in);
        chan_irq_in <= 17'h0_0000;
        rd(lis_pkg::OFS_SUM_UPPER, rv);
        chk(rv, 8'h00, "summary cleared");
        $display("test done: summaries");
        wr(lis_pkg::OFS_IRQ_MASK, 8'h01);
        chk(irq_out, 1'h0, "no event yet");
        tick();
        chk(irq_out, 1'h1, "irq raised");
        rd(lis_pkg::OFS_TM_STATUS, rv);
        chk(rv, 8'h01, "flag set");
        wr(lis_pkg::OFS_TM_STATUS, 8'hfe);
        rd(lis_pkg::OFS_TM_STATUS, rv);
        chk(rv, 8'h01, "zero write kept");
        wr(lis_pkg::OFS_IRQ_MASK, 8'h00);
        chk(irq_out, 1'h0, "masked");
        wr(lis_pkg::OFS_IRQ_MASK, 8'h01);
        chk(irq_out, 1'h1, "unmasked");
        wr(lis_pkg::OFS_TM_STATUS, 8'h01);
        chk(irq_out, 1'h0, "irq cleared");
        rd(lis_pkg::OFS_TM_STATUS, rv);
        chk(rv, 8'h00, "flag cleared");
        $display("test done: timer flag");
        for (int k = 0; k < 17; k++) begin
            seed = xorshift(seed);
            mode = seed[0];
            exp_mode[k] = mode;
            wr(cfg_addr(k), {6'h00, 1'h1, mode});
            chk(chan_soft_reset_out, 17'h0_0001 << k, "reset pulse");
            chk(line_standard_select_out[k], mode, "mode out");
            @(posedge ref_clk_in);
            #1;
            chk(chan_soft_reset_out, 17'h0_0000, "pulse ended");
            rd(cfg_addr(k), rv);
            chk(rv, {7'h00, mode}, "cfg readback");
        end
        chk(line_standard_select_out, exp_mode, "modes kept");
        $display("test done: channel config");
        conclude();
    end
endmodule
